/* common/adcr_defines.svh */
// register indices, field positions, reset values and counts for adcr
`ifndef ADCR_DEFINES_SVH
`define ADCR_DEFINES_SVH

// register indices, byte address is four times the index
`define ADCR_IDX_RES_LO 6'h0e
`define ADCR_IDX_RES_HI 6'h0f
`define ADCR_IDX_MUX    6'h10
`define ADCR_IDX_CSRB   6'h11
`define ADCR_IDX_CSRA   6'h12

// converter_control_status fields
`define ADCR_A_EN    7
`define ADCR_A_START 6
`define ADCR_A_ATE   5
`define ADCR_A_FLAG  4
`define ADCR_A_IE    3

// channel_reference_select fields and writable mask
`define ADCR_M_REF   6
`define ADCR_M_WMASK 8'h7f

// trigger_align_control fields and writable mask
`define ADCR_B_ALIGN 3
`define ADCR_B_WMASK 8'hcf

// reset value of every register
`define ADCR_RST_BYTE 8'h00

// conversion length in converter clock cycles
`define ADCR_CYC_NORMAL 5'd13
`define ADCR_CYC_LONG   5'd25

// settle wait after switching to the internal reference, 1 ms at 50 MHz
`define ADCR_REF_SETTLE_CYC 32'h0000_c350

// channel codes
`define ADCR_CH_AGND 4'h8
`define ADCR_CH_TEMP 4'ha

// bus responses
`define ADCR_RESP_OKAY   2'b00
`define ADCR_RESP_SLVERR 2'b10

`endif

/* common/adcr_pkg.sv */
// types shared by the adcr converter control block
package adcr_pkg;

   // axi4-lite requests from the master
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } adcr_axi_req_t;

   // axi4-lite answers of the slave
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } adcr_axi_rsp_t;

   // conversion sequencer
   typedef enum logic {ADCR_IDLE, ADCR_CONV} adcr_state_t;

   // decoded register
   typedef enum logic [2:0] {
      ADCR_RG_NONE, ADCR_RG_LO, ADCR_RG_HI,
      ADCR_RG_MUX, ADCR_RG_CSRB, ADCR_RG_CSRA
   } adcr_sel_t;

endpackage

/* verilog/adcr_top.sv */
// adc control registers, conversion sequencer and axi4-lite slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adcr_defines.svh"

module adcr_top (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // register bus
   input  wire adcr_pkg::adcr_axi_req_t busReq,
   output adcr_pkg::adcr_axi_rsp_t      busRsp,
   // processor interrupt side
   input  wire logic                    gieIn,
   input  wire logic                    irqAck,
   output logic                         irqOut,
   // trigger sources for codes 1 to 7
   input  wire logic [7:1]              trigIn,
   // analog core
   input  wire logic [9:0]              sampleCode,
   output logic                         anaPower,
   output logic                         refInternal,
   output logic [3:0]                   anaChannel,
   output logic                         convBusy
);
   import adcr_pkg::*;

   // shared address decode for read and write
   function automatic adcr_sel_t decodeReg(input logic [7:0] a);
      adcr_sel_t s;
      s = ADCR_RG_NONE;
      if (a[1:0] == 2'h0) begin
         unique case (a[7:2])
            `ADCR_IDX_RES_LO: s = ADCR_RG_LO;
            `ADCR_IDX_RES_HI: s = ADCR_RG_HI;
            `ADCR_IDX_MUX:    s = ADCR_RG_MUX;
            `ADCR_IDX_CSRB:   s = ADCR_RG_CSRB;
            `ADCR_IDX_CSRA:   s = ADCR_RG_CSRA;
            default:          s = ADCR_RG_NONE;
         endcase
      end
      return s;
   endfunction

   // prescaler mask: tick when masked counter bits are all ones
   function automatic logic [6:0] divMask(input logic [2:0] c);
      return (c <= 3'h1) ? 7'h01 : 7'h7f >> (3'h7 - c);
   endfunction

   // bus state
   logic        liveReg;
   logic        awRdyReg, wRdyReg, bvalidReg, arRdyReg, rvalidReg;
   logic [7:0]  awAddrReg;
   logic [7:0]  wDataReg;
   logic        wLaneReg;
   logic [1:0]  brespReg, rrespReg;
   logic [31:0] rdataReg;
   // register file
   logic [7:0]  muxReg, csrbReg;
   logic        enReg, busyReg, ateReg, flagReg, ieReg;
   logic [2:0]  psReg;
   logic [9:0]  resultReg;
   logic        lockReg;
   // sequencer
   adcr_state_t stateReg;
   logic [6:0]  preReg;
   logic [4:0]  cycReg, targetReg;
   logic        initDoneReg, lastRefReg, trigPrevReg;
   logic [9:0]  smp1Reg, smp2Reg, smp3Reg, codeReg;
   logic        irqReg;

   // decoded strobes
   logic        wrFire, wrCsra;
   logic [7:0]  wd;
   adcr_sel_t   wrSel, rdSel;
   logic        arFire, tick, done, enNext, trigSel, trigEdge;
   logic        swStart, autoStart, startNow, longConv, abort;
   logic [7:0]  rdByte;
   logic [7:0]  trigVec;

   assign wrFire = liveReg & ~awRdyReg & ~wRdyReg & ~bvalidReg;
   assign wrSel  = decodeReg(awAddrReg);
   assign wd     = wDataReg;
   assign wrCsra = wrFire & wLaneReg & (wrSel == ADCR_RG_CSRA);
   assign arFire = busReq.arvalid & arRdyReg;
   assign rdSel  = decodeReg(busReq.araddr);

   // every answer comes straight from a flop
   assign busRsp = '{awready: awRdyReg, wready: wRdyReg,
                     bvalid: bvalidReg, bresp: brespReg,
                     arready: arRdyReg, rvalid: rvalidReg,
                     rdata: rdataReg, rresp: rrespReg};

   // readies open one edge after reset release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         liveReg <= 1'b0;
      end else begin
         liveReg <= 1'b1;
      end
   end

   // write address and data taken in either order
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awRdyReg  <= 1'b0;
         wRdyReg   <= 1'b0;
         awAddrReg <= 8'h00;
         wDataReg  <= 8'h00;
         wLaneReg  <= 1'b0;
      end else begin
         if (busReq.awvalid && awRdyReg) begin
            awRdyReg  <= 1'b0;
            awAddrReg <= busReq.awaddr;
         end else if (!liveReg || (bvalidReg && busReq.bready)) begin
            awRdyReg <= 1'b1;
         end
         if (busReq.wvalid && wRdyReg) begin
            wRdyReg  <= 1'b0;
            wDataReg <= busReq.wdata[7:0];
            wLaneReg <= busReq.wstrb[0];
         end else if (!liveReg || (bvalidReg && busReq.bready)) begin
            wRdyReg <= 1'b1;
         end
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalidReg <= 1'b0;
         brespReg  <= `ADCR_RESP_OKAY;
      end else if (wrFire) begin
         bvalidReg <= 1'b1;
         brespReg  <= (wrSel == ADCR_RG_NONE) ? `ADCR_RESP_SLVERR
                                              : `ADCR_RESP_OKAY;
      end else if (busReq.bready) begin
         bvalidReg <= 1'b0;
      end
   end

   // read byte assembly, alignment applied at read time
   always_comb begin
      rdByte = 8'h00;
      unique case (rdSel)
         ADCR_RG_LO:   rdByte = csrbReg[`ADCR_B_ALIGN] ?
                                {resultReg[1:0], 6'h00} :
                                resultReg[7:0];
         ADCR_RG_HI:   rdByte = csrbReg[`ADCR_B_ALIGN] ?
                                resultReg[9:2] :
                                {6'h00, resultReg[9:8]};
         ADCR_RG_MUX:  rdByte = {1'b0, muxReg[6:0]};
         ADCR_RG_CSRB: rdByte = csrbReg;
         ADCR_RG_CSRA: rdByte = {enReg, busyReg, ateReg, flagReg,
                                 ieReg, psReg};
         ADCR_RG_NONE: rdByte = 8'h00;
      endcase
   end

   // read channel, one request under way at a time
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arRdyReg  <= 1'b0;
         rvalidReg <= 1'b0;
         rdataReg  <= 32'h0000_0000;
         rrespReg  <= `ADCR_RESP_OKAY;
      end else if (arFire) begin
         arRdyReg  <= 1'b0;
         rvalidReg <= 1'b1;
         rdataReg  <= {24'h00_0000, rdByte};
         rrespReg  <= (rdSel == ADCR_RG_NONE) ? `ADCR_RESP_SLVERR
                                              : `ADCR_RESP_OKAY;
      end else if (rvalidReg && busReq.rready) begin
         rvalidReg <= 1'b0;
         arRdyReg  <= 1'b1;
      end else if (!liveReg) begin
         arRdyReg <= 1'b1;
      end
   end

   // low byte read freezes the result until the high byte is read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lockReg <= 1'b0;
      end else if (arFire && rdSel == ADCR_RG_LO) begin
         lockReg <= 1'b1;
      end else if (arFire && rdSel == ADCR_RG_HI) begin
         lockReg <= 1'b0;
      end
   end

   // mux and trigger/align registers; reserved bits masked to zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         muxReg  <= `ADCR_RST_BYTE;
         csrbReg <= `ADCR_RST_BYTE;
      end else if (wrFire && wLaneReg) begin
         if (wrSel == ADCR_RG_MUX) begin
            muxReg <= wd & `ADCR_M_WMASK;
         end
         if (wrSel == ADCR_RG_CSRB) begin
            csrbReg <= wd & `ADCR_B_WMASK;
         end
      end
   end

   // control bits of converter_control_status
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         enReg  <= 1'b0;
         ateReg <= 1'b0;
         ieReg  <= 1'b0;
         psReg  <= 3'h0;
      end else if (wrCsra) begin
         enReg  <= wd[`ADCR_A_EN];
         ateReg <= wd[`ADCR_A_ATE];
         ieReg  <= wd[`ADCR_A_IE];
         psReg  <= wd[2:0];
      end
   end

   // free-running prescaler; the first tick of a conversion may be short
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         preReg <= 7'h00;
      end else begin
         preReg <= preReg + 7'h01;
      end
   end
   assign tick = (preReg & divMask(psReg)) == divMask(psReg);

   // trigger edge; code zero selects nothing, so switching to it makes no edge, but switching from it to a high source does
   assign trigVec = {trigIn, 1'b0};
   assign trigSel = trigVec[csrbReg[2:0]];
   assign trigEdge = trigSel & ~trigPrevReg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigPrevReg <= 1'b0;
      end else begin
         trigPrevReg <= trigSel;
      end
   end

   // start and stop decisions
   assign enNext    = wrCsra ? wd[`ADCR_A_EN] : enReg;
   assign abort     = ~enNext;
   assign swStart   = wrCsra & wd[`ADCR_A_START];
   assign autoStart = ateReg & enReg & (csrbReg[2:0] != 3'h0)
                      & trigEdge;
   assign startNow  = enNext & (stateReg == ADCR_IDLE)
                      & (swStart | autoStart);
   assign longConv  = ~initDoneReg
                      | (muxReg[`ADCR_M_REF] != lastRefReg);
   assign done      = (stateReg == ADCR_CONV) & tick
                      & (cycReg == targetReg - 5'd1) & enNext;

   // conversion sequencer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg    <= ADCR_IDLE;
         busyReg     <= 1'b0;
         cycReg      <= 5'd0;
         targetReg   <= `ADCR_CYC_NORMAL;
         initDoneReg <= 1'b0;
         lastRefReg  <= 1'b0;
      end else if (abort) begin
         stateReg    <= ADCR_IDLE;
         busyReg     <= 1'b0;
         initDoneReg <= 1'b0;
      end else if (startNow) begin
         stateReg  <= ADCR_CONV;
         busyReg   <= 1'b1;
         cycReg    <= 5'd0;
         targetReg <= longConv ? `ADCR_CYC_LONG
                               : `ADCR_CYC_NORMAL;
      end else if (done) begin
         initDoneReg <= 1'b1;
         lastRefReg  <= refInternal;
         cycReg      <= 5'd0;
         if (ateReg && csrbReg[2:0] == 3'h0) begin
            // free running: chain the next conversion at once
            targetReg <= (muxReg[`ADCR_M_REF] != refInternal) ?
                         `ADCR_CYC_LONG : `ADCR_CYC_NORMAL;
         end else begin
            stateReg <= ADCR_IDLE;
            busyReg  <= 1'b0;
         end
      end else if (stateReg == ADCR_CONV && tick) begin
         cycReg <= cycReg + 5'd1;
      end
   end

   // analog selection held while converting, refreshed between
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         refInternal <= 1'b0;
         anaChannel  <= 4'h0;
      end else if (stateReg == ADCR_IDLE || done) begin
         refInternal <= muxReg[`ADCR_M_REF];
         anaChannel  <= muxReg[3:0];
      end
   end

   // analog code synchroniser, accepted once stages two and three agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         smp1Reg <= 10'h000;
         smp2Reg <= 10'h000;
         smp3Reg <= 10'h000;
         codeReg <= 10'h000;
      end else begin
         smp1Reg <= sampleCode;
         smp2Reg <= smp1Reg;
         smp3Reg <= smp2Reg;
         if (smp2Reg == smp3Reg) begin
            codeReg <= smp3Reg;
         end
      end
   end

   // result capture; ground and reserved codes read as zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         resultReg <= 10'h000;
      end else if (done && !lockReg) begin
         if (anaChannel == `ADCR_CH_AGND ||
             anaChannel > `ADCR_CH_TEMP) begin
            resultReg <= 10'h000;
         end else begin
            resultReg <= codeReg;
         end
      end
   end

   // done flag; a completion in the clearing cycle wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flagReg <= 1'b0;
      end else if (done) begin
         flagReg <= 1'b1;
      end else if (irqAck || (wrCsra && wd[`ADCR_A_FLAG])) begin
         flagReg <= 1'b0;
      end
   end

   // interrupt request, one cycle behind its gating terms
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqReg <= 1'b0;
      end else begin
         irqReg <= flagReg & ieReg & gieIn;
      end
   end

   assign irqOut   = irqReg;
   assign anaPower = enReg;
   assign convBusy = busyReg;

   // checks
   chk_mux_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
      muxReg[7] == 1'b0)
      else $error("channel register msb not zero");
   chk_first_long: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      startNow && !abort && !initDoneReg |=> targetReg == 5'd25)
      else $error("first conversion not 25 cycles");
   chk_normal_len: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      startNow && !abort && initDoneReg
      && muxReg[6] == lastRefReg |=> targetReg == 5'd13)
      else $error("normal conversion not 13 cycles");
   chk_ref_long: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      startNow && !abort && muxReg[6] != lastRefReg
      |=> targetReg == 5'd25)
      else $error("reference change not 25 cycles");
   chk_flag_done: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      done |=> flagReg && (busyReg == (ateReg && csrbReg[2:0] == 3'h0)))
      else $error("done did not set flag");
   chk_flag_clear: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      irqAck && !done |=> !flagReg)
      else $error("vector did not clear flag");
   chk_abort_off: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      wrCsra && !wd[7] |=> !busyReg && stateReg == ADCR_IDLE)
      else $error("disable did not abort");
   chk_lock_hold: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      lockReg && !(arFire && rdSel == ADCR_RG_HI)
      |=> $stable(resultReg))
      else $error("locked result changed");
   chk_chan_hold: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      busyReg && !done ##1 busyReg |-> $stable(anaChannel))
      else $error("channel changed mid conversion");
   chk_start_busy: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      startNow |=> busyReg ##0 convBusy)
      else $error("start did not set busy");
   chk_irq_gate: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      irqOut |-> $past(flagReg) && $past(ieReg) && $past(gieIn))
      else $error("interrupt without cause");

   cov_done: cover property (@(posedge core_clk) disable iff (!rst_n)
      done && !lockReg);
   cov_long: cover property (@(posedge core_clk) disable iff (!rst_n)
      done && targetReg == 5'd25);
   cov_auto: cover property (@(posedge core_clk) disable iff (!rst_n)
      startNow && autoStart);

endmodule // adcr_top

/* bench/adcr_ana_model.sv */
// behavioural analog core stub facing the converter control block
`timescale 1ns/1ps

module adcr_ana_model (
   // clock
   input  wire logic       core_clk,
   // control from the block
   input  wire logic       anaPower,
   input  wire logic       refInternal,
   input  wire logic [3:0] anaChannel,
   // conversion code
   output logic      [9:0] sampleCode
);
   // code carries reference and channel so routing shows in results
   // an unpowered core toggles, so a stale code can never look valid
   initial sampleCode = 10'h2aa;
   always @(posedge core_clk) begin
      if (anaPower) begin
         sampleCode <= {refInternal, 5'h15, anaChannel};
      end else begin
         sampleCode <= ~sampleCode;
      end
   end
endmodule // adcr_ana_model

/* bench/tb.sv */
// self-checking bench for the adcr converter control block
`timescale 1ns/1ps
`include "adcr_defines.svh"

module tb;
   import adcr_pkg::*;
   localparam logic [7:0] A_LO = {`ADCR_IDX_RES_LO, 2'b00};
   localparam logic [7:0] A_HI = {`ADCR_IDX_RES_HI, 2'b00};
   localparam logic [7:0] A_MX = {`ADCR_IDX_MUX, 2'b00};
   localparam logic [7:0] A_CB = {`ADCR_IDX_CSRB, 2'b00};
   localparam logic [7:0] A_CA = {`ADCR_IDX_CSRA, 2'b00};
   logic          core_clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          gieIn = 1'b0;
   logic          irqAck = 1'b0;
   logic [7:1]    trigIn = '0;
   adcr_axi_req_t req = '0;
   adcr_axi_rsp_t rsp;
   logic          irqOut;
   logic          anaPower;
   logic          refInternal;
   logic          convBusy;
   logic [3:0]    anaChannel;
   logic [9:0]    sampleCode;
   logic [1:0]    lastResp;
   int            n_mismatch = 0;
   int            total_checks = 0;

   always #10 core_clk = ~core_clk;

   adcr_top u_adcr_top (.core_clk, .rst_n, .busReq(req), .busRsp(rsp),
      .gieIn, .irqAck, .irqOut, .trigIn, .sampleCode, .anaPower,
      .refInternal, .anaChannel, .convBusy);
   adcr_ana_model u_adcr_ana_model (.core_clk, .anaPower, .refInternal,
      .anaChannel, .sampleCode);

   // expected code: ground and reserved codes give zero
   function automatic logic [9:0] code(input logic r, input logic [3:0] c);
      return (c == `ADCR_CH_AGND || c > `ADCR_CH_TEMP) ? 10'h000
         : {r, 5'h15, c};
   endfunction

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // axi4-lite write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s = 4'hf);
      int n;
      n = 0;
      @(posedge core_clk);
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.awaddr <= a;
      req.wdata <= {24'h0, d};
      req.wstrb <= s;
      req.bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 200);
      req.bready <= 1'b0;
      lastResp = rsp.bresp;
      if (n >= 200) n_mismatch++;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 200);
      req.rready <= 1'b0;
      d = rsp.rdata[7:0];
      lastResp = rsp.rresp;
      if (n >= 200) n_mismatch++;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({8'h0, d}, {8'h0, e});
   endtask

   // bounded wait for the sequencer to go idle
   task automatic waitIdle(output int len);
      len = 0;
      while (convBusy !== 1'b0 && len < 5000) begin
         @(posedge core_clk);
         len++;
      end
      if (len >= 5000) n_mismatch++;
   endtask

   // first tick may be partial, so allow one divider period short
   task automatic convLen(input int t, input int dv);
      int len;
      waitIdle(len);
      chk(16'(len >= (t - 1) * dv - 3 && len <= t * dv + 3), 16'h1);
   endtask

   task automatic tReset;
      rc(A_LO, `ADCR_RST_BYTE);
      rc(A_HI, `ADCR_RST_BYTE);
      rc(A_MX, `ADCR_RST_BYTE);
      rc(A_CB, `ADCR_RST_BYTE);
      rc(A_CA, `ADCR_RST_BYTE);
      rc(8'h00, 8'h00);
      chk(16'(lastResp), 16'(`ADCR_RESP_SLVERR));
      wr(8'h4c, 8'hff);
      chk(16'(lastResp), 16'(`ADCR_RESP_SLVERR));
      // byte lane 0 off: write ignored but answered okay
      wr(A_MX, 8'hcf, 4'h0);
      chk(16'(lastResp), 16'(`ADCR_RESP_OKAY));
      rc(A_MX, 8'h00);
      chk(16'(lastResp), 16'(`ADCR_RESP_OKAY));
      wr(A_MX, 8'hcf);
      rc(A_MX, 8'h4f);
      wr(A_CB, 8'h3f);
      rc(A_CB, 8'h0f);
      wr(A_MX, 8'h00);
      wr(A_CB, 8'h00);
      $display("test reset and masks end");
   endtask

   task automatic tFirst;
      wr(A_CA, 8'hc0);
      chk(16'(anaPower), 16'h1);
      rc(A_CA, 8'hc0);
      convLen(25, 2);
      rc(A_CA, 8'h90);
      wr(A_CA, 8'h90);
      rc(A_CA, 8'h80);
      chk(16'(convBusy), 16'h0);
      wr(A_CA, 8'hc0);
      convLen(13, 2);
      $display("test first conversion end");
   endtask

   // last pass lands on channel 3 for the following tests
   task automatic tChan;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [3:0] ch;
      int         len;
      for (int i = 0; i < 16; i++) begin
         ch = 4'(i) ^ 4'hc;
         wr(A_MX, {4'h0, ch});
         wr(A_CA, 8'hd0);
         waitIdle(len);
         rd(A_LO, lo);
         rd(A_HI, hi);
         chk({hi, lo}, {6'h0, code(1'b0, ch)});
      end
      $display("test channels end");
   endtask

   task automatic tAlign;
      int len;
      wr(A_CA, 8'hd0);
      wr(A_CA, 8'h80);
      chk(16'(convBusy), 16'h1);
      wr(A_CB, 8'h08);
      rc(A_HI, 8'h54);
      waitIdle(len);
      rc(A_LO, 8'hc0);
      rc(A_HI, 8'h54);
      wr(A_CB, 8'h00);
      rc(A_HI, 8'h01);
      $display("test alignment end");
   endtask

   task automatic tLock;
      int len;
      // locked conversion runs on channel 5, so an update would show
      rc(A_LO, 8'h53);
      wr(A_MX, 8'h05);
      wr(A_CA, 8'hd0);
      wr(A_MX, 8'h06);
      chk(16'(anaChannel), 16'h5);
      waitIdle(len);
      chk(16'(anaChannel), 16'h6);
      rc(A_HI, 8'h01);
      rc(A_LO, 8'h53);
      rc(A_HI, 8'h01);
      wr(A_CA, 8'hd0);
      waitIdle(len);
      rc(A_LO, 8'h56);
      rc(A_HI, 8'h01);
      $display("test result lock end");
   endtask

   task automatic tDiv;
      for (int d = 0; d < 8; d++) begin
         wr(A_CA, 8'hd0 | 8'(d));
         convLen(13, d < 2 ? 2 : 1 << d);
      end
      $display("test prescaler end");
   endtask

   task automatic tRef;
      int len;
      wr(A_CA, 8'hd0);
      wr(A_MX, 8'h45);
      chk(16'(refInternal), 16'h0);
      waitIdle(len);
      chk(16'(refInternal), 16'h1);
      // converter stays on while the internal reference settles
      repeat (`ADCR_REF_SETTLE_CYC) @(posedge core_clk);
      wr(A_CA, 8'hd0);
      convLen(25, 2);
      rc(A_LO, 8'h55);
      rc(A_HI, 8'h03);
      wr(A_CA, 8'hd0);
      wr(A_CA, 8'h00);
      chk(16'(convBusy), 16'h0);
      chk(16'(anaPower), 16'h0);
      rc(A_CA, 8'h00);
      $display("test reference and abort end");
   endtask

   task automatic tIrq;
      int len;
      gieIn <= 1'b1;
      wr(A_CA, 8'hc8);
      waitIdle(len);
      repeat (2) @(posedge core_clk);
      chk(16'(irqOut), 16'h1);
      irqAck <= 1'b1;
      @(posedge core_clk);
      irqAck <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(16'(irqOut), 16'h0);
      rc(A_CA, 8'h88);
      gieIn <= 1'b0;
      wr(A_CA, 8'hc8);
      waitIdle(len);
      repeat (2) @(posedge core_clk);
      chk(16'(irqOut), 16'h0);
      $display("test interrupt end");
   endtask

   task automatic tTrig;
      int len;
      for (int k = 1; k < 8; k++) begin
         wr(A_CB, 8'(k));
         wr(A_CA, 8'hb0);
         @(posedge core_clk);
         trigIn[k] <= 1'b1;
         @(posedge core_clk);
         trigIn[k] <= 1'b0;
         repeat (2) @(posedge core_clk);
         chk(16'(convBusy), 16'h1);
         waitIdle(len);
      end
      wr(A_CB, 8'h00);
      repeat (3) @(posedge core_clk);
      chk(16'(convBusy), 16'h0);
      wr(A_CA, 8'he0);
      repeat (80) @(posedge core_clk);
      rc(A_CA, 8'hf0);
      wr(A_CA, 8'h00);
      $display("test auto trigger end");
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // registers are always written whole, never read-modify-write
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      tReset;
      tFirst;
      tChan;
      tAlign;
      tLock;
      tDiv;
      tRef;
      tIrq;
      tTrig;
      summarize;
   end

   // watchdog, margin over the tests plus the reference settle wait
   initial begin
      #1500us;
      n_mismatch++;
      summarize;
   end
endmodule // tb
